// file: hw/spm_port.sv
// Top of the SPI master/slave port: Wishbone registers, shift engine,
// flag handling and pin drivers.
// Assumes a classic Wishbone master and an external SPI party on pins.
//
// Implementation choice: register access over Wishbone.
module spm_port (
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RESET_N_IN,
  // Wishbone slave
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [7:0]  WB_ADR_IN,
  input  wire logic [31:0] WB_DAT_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  output logic      [31:0] WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  // Processor side
  input  wire logic        CPU_IRQ_EN_IN,
  input  wire logic        IRQ_TAKEN_IN,
  output logic             IRQ_OUT,
  // Serial clock pin
  input  wire logic        SCK_IN,
  output logic             SCK_OUT,
  output logic             SCK_OE_OUT,
  // Master-out pin
  input  wire logic        MOSI_IN,
  output logic             MOSI_OUT,
  output logic             MOSI_OE_OUT,
  // Master-in pin
  input  wire logic        MISO_IN,
  output logic             MISO_OUT,
  output logic             MISO_OE_OUT,
  // Select pin, active low on the wire
  input  wire logic        SS_N_IN,
  output logic             SS_N_OUT,
  output logic             SS_N_OE_OUT
);

  logic [7:0]      ctrl_q;
  logic            double_q;
  logic [4:0]      dir_q;
  logic            done_q;
  logic            coll_q;
  logic            arm_done_q;
  logic            arm_coll_q;
  logic [7:0]      rx_buf_q;
  logic [7:0]      sh_q;
  logic            out_bit_q;
  logic            sck_q;
  logic            sck_prev_q;
  logic [3:0]      cnt_q;
  spm_pkg::spm_state_t state_q;
  logic            ack_q;
  logic [31:0]     rdata_q;
  logic [3:0]      sync_w;
  logic            tick_w;

  function automatic logic hit(input logic [7:0] adr,
                               input logic [5:0] idx);
    return adr == {idx, 2'b00};
  endfunction : hit

  // Bus decode; one access per request, taken as ack rises
  logic req_w, wr_w, rd_w, wr_ctrl_w, wr_stat_w, wr_dir_w;
  logic wr_data_w, acc_data_w, rd_stat_w;
  assign req_w      = WB_CYC_IN && WB_STB_IN && !ack_q;
  assign wr_w       = req_w && WB_WE_IN && WB_SEL_IN[0];
  assign rd_w       = req_w && !WB_WE_IN;
  assign wr_ctrl_w  = wr_w && hit(WB_ADR_IN, spm_pkg::IDX_CONTROL);
  assign wr_stat_w  = wr_w && hit(WB_ADR_IN, spm_pkg::IDX_STATUS);
  assign wr_dir_w   = wr_w && hit(WB_ADR_IN, spm_pkg::IDX_PINDIR);
  assign wr_data_w  = wr_w && hit(WB_ADR_IN, spm_pkg::IDX_DATA);
  assign rd_stat_w  = rd_w && hit(WB_ADR_IN, spm_pkg::IDX_STATUS);
  assign acc_data_w = wr_data_w ||
                      (rd_w && hit(WB_ADR_IN, spm_pkg::IDX_DATA));

  // Control fields
  logic en_w, master_w, lsb_w, idle_w, phase_w;
  assign en_w     = ctrl_q[spm_pkg::B_PORT_EN];
  assign master_w = ctrl_q[spm_pkg::B_MASTER];
  assign lsb_w    = ctrl_q[spm_pkg::B_ORDER];
  assign idle_w   = ctrl_q[spm_pkg::B_IDLE_LVL];
  assign phase_w  = ctrl_q[spm_pkg::B_PHASE];

  // Pins pass two flops before use
  spm_sync u_sync (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .pins_in    ({SS_N_IN, SCK_IN, MOSI_IN, MISO_IN}),
    .pins_out   (sync_w)
  );

  logic ss_s, sck_s, mosi_s, miso_s;
  assign {ss_s, sck_s, mosi_s, miso_s} = sync_w;

  // Role and activity
  logic slave_act_w, fault_w, busy_w, xfer_w, start_w;
  assign slave_act_w = en_w && !master_w && !ss_s;
  assign fault_w  = en_w && master_w && !dir_q[spm_pkg::D_SS] && !ss_s;
  assign busy_w   = (state_q == spm_pkg::ST_SHIFT);
  assign xfer_w   = busy_w || (slave_act_w && cnt_q != 4'h0);
  assign start_w  = wr_data_w && !xfer_w && en_w && master_w && !fault_w;

  // Rate bits only reach the master divider
  spm_rate_div u_div (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .run_in     (busy_w),
    .half_in    (spm_pkg::rate_half({double_q, ctrl_q[1:0]})),
    .tick_out   (tick_w)
  );

  // Edge events; even master edges are leading ones
  logic sck_chg_w, lead_w, trail_w, sample_w, setup_w, in_bit_w;
  logic head_w, done_w;
  logic [7:0] shifted_w;
  assign sck_chg_w = slave_act_w && (sck_s != sck_prev_q);
  assign lead_w  = master_w ? (tick_w && !cnt_q[0])
                            : (sck_chg_w && sck_prev_q == idle_w);
  assign trail_w = master_w ? (tick_w && cnt_q[0])
                            : (sck_chg_w && sck_prev_q != idle_w);
  assign sample_w  = phase_w ? trail_w : lead_w;
  assign setup_w   = phase_w ? lead_w : trail_w;
  assign in_bit_w  = master_w ? miso_s : mosi_s;
  assign head_w    = lsb_w ? sh_q[0] : sh_q[7];
  assign shifted_w = lsb_w ? {in_bit_w, sh_q[7:1]}
                           : {sh_q[6:0], in_bit_w};
  assign done_w    = master_w
                   ? (tick_w && cnt_q == spm_pkg::LAST_EDGE)
                   : (sample_w && cnt_q == spm_pkg::LAST_SAMPLE);

  // Previous synchronised SCK for slave edge detection
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      sck_prev_q <= 1'b1; // Matches synchroniser reset, no false edge
    else
      sck_prev_q <= sck_s;
  end

  // Bus acknowledge, one cycle after the request
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      ack_q <= 1'b0;
    else
      ack_q <= req_w;
  end

  // Control register; a forced drop beats a software write
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      ctrl_q <= spm_pkg::RST_CONTROL;
    else if (fault_w)
      ctrl_q[spm_pkg::B_MASTER] <= 1'b0;
    else if (wr_ctrl_w)
      ctrl_q <= WB_DAT_IN[7:0];
  end

  // Double rate bit and pin directions
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      double_q <= 1'b0;
      dir_q    <= spm_pkg::RST_PINDIR;
    end
    else
    begin
      if (wr_stat_w)
        double_q <= WB_DAT_IN[spm_pkg::B_DOUBLE];
      if (wr_dir_w)
        dir_q <= WB_DAT_IN[4:0];
    end
  end

  // Byte sequencer: master counts edges, slave counts samples
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      state_q <= spm_pkg::ST_IDLE;
      cnt_q   <= 4'h0;
    end
    else if (!en_w || fault_w)
    begin
      state_q <= spm_pkg::ST_IDLE;
      cnt_q   <= 4'h0;
    end
    else if (master_w)
    begin
      if (start_w)
      begin
        state_q <= spm_pkg::ST_SHIFT;
        cnt_q   <= 4'h0;
      end
      else if (tick_w)
      begin
        cnt_q <= 4'(cnt_q + 4'h1);
        if (cnt_q == spm_pkg::LAST_EDGE)
          state_q <= spm_pkg::ST_IDLE;
      end
    end
    else
    begin
      state_q <= spm_pkg::ST_IDLE;
      if (ss_s)
        cnt_q <= 4'h0;
      else if (sample_w)
        cnt_q <= (cnt_q == spm_pkg::LAST_SAMPLE) ? 4'h0
                                                 : 4'(cnt_q + 4'h1);
    end
  end

  // Master SCK rests at the idle level outside a byte
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      sck_q <= 1'b0;
    else if (!busy_w)
      sck_q <= idle_w;
    else if (tick_w)
      sck_q <= !sck_q;
  end

  // Shift register and output bit; writes mid-byte are refused
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      sh_q      <= 8'h00;
      out_bit_q <= 1'b0;
    end
    else if (wr_data_w && !xfer_w)
    begin
      sh_q      <= WB_DAT_IN[7:0];
      out_bit_q <= lsb_w ? WB_DAT_IN[0] : WB_DAT_IN[7];
    end
    else if (!master_w && ss_s)
      out_bit_q <= head_w;
    else if (sample_w)
      sh_q <= shifted_w;
    else if (setup_w)
      out_bit_q <= head_w;
  end

  // Receive buffer; an unread byte is simply overwritten
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      rx_buf_q <= 8'h00;
    else if (done_w)
      rx_buf_q <= sample_w ? shifted_w : sh_q;
  end

  // Flags; a set in the clearing cycle wins
  logic clr_seq_w;
  assign clr_seq_w = acc_data_w && (arm_done_q || arm_coll_q);
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      done_q <= 1'b0;
      coll_q <= 1'b0;
    end
    else
    begin
      if (done_w || fault_w)
        done_q <= 1'b1;
      else if (IRQ_TAKEN_IN || clr_seq_w)
        done_q <= 1'b0;
      if (wr_data_w && xfer_w)
        coll_q <= 1'b1;
      else if (acc_data_w && arm_coll_q)
        coll_q <= 1'b0;
    end
  end

  // Status read with a flag set arms the clear by a data access
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      arm_done_q <= 1'b0;
      arm_coll_q <= 1'b0;
    end
    else if (acc_data_w)
    begin
      arm_done_q <= 1'b0;
      arm_coll_q <= 1'b0;
    end
    else if (rd_stat_w)
    begin
      arm_done_q <= done_q;
      arm_coll_q <= coll_q;
    end
  end

  // Read data, registered with the acknowledge; unmapped reads zero
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      rdata_q <= 32'h0000_0000;
    else if (rd_w)
    begin
      rdata_q <= 32'h0000_0000;
      if (hit(WB_ADR_IN, spm_pkg::IDX_CONTROL))
        rdata_q[7:0] <= ctrl_q;
      else if (hit(WB_ADR_IN, spm_pkg::IDX_STATUS))
        rdata_q[7:0] <= {done_q, coll_q, 5'h00, double_q};
      else if (hit(WB_ADR_IN, spm_pkg::IDX_DATA))
        rdata_q[7:0] <= rx_buf_q;
      else if (hit(WB_ADR_IN, spm_pkg::IDX_PINDIR))
        rdata_q[4:0] <= dir_q;
    end
  end

  assign WB_ACK_OUT = ack_q;
  assign WB_DAT_OUT = rdata_q;
  assign IRQ_OUT    = done_q && ctrl_q[spm_pkg::B_IRQ_EN]
                      && CPU_IRQ_EN_IN;

  // Pin drivers; only master drives SCK and MOSI
  assign SCK_OUT     = sck_q;
  assign SCK_OE_OUT  = en_w && master_w && dir_q[spm_pkg::D_SCK];
  assign MOSI_OUT    = out_bit_q;
  assign MOSI_OE_OUT = en_w && master_w && dir_q[spm_pkg::D_MOSI];
  assign MISO_OUT    = out_bit_q;
  assign MISO_OE_OUT = slave_act_w && dir_q[spm_pkg::D_MISO];
  assign SS_N_OUT    = dir_q[spm_pkg::D_SS_LEVEL];
  assign SS_N_OE_OUT = dir_q[spm_pkg::D_SS] && !(en_w && !master_w);

  // Checks
  chk_fault_drop: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    fault_w |=> !ctrl_q[spm_pkg::B_MASTER] && done_q && !SCK_OE_OUT)
    else $error("forced drop did not leave master role");

  chk_fault_flag: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    fault_w && ctrl_q[spm_pkg::B_IRQ_EN] && CPU_IRQ_EN_IN
      |=> IRQ_OUT || !CPU_IRQ_EN_IN || !ctrl_q[spm_pkg::B_IRQ_EN])
    else $error("forced drop raised no interrupt");

  chk_slave_reset: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    en_w && !master_w && ss_s |-> !MISO_OE_OUT ##1 cnt_q == 4'h0)
    else $error("deselected slave kept its bit count");

  chk_sck_idle: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    !busy_w |=> sck_q == $past(idle_w))
    else $error("SCK not at idle level between bytes");

  chk_done_set: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    done_w |=> done_q ##0 rx_buf_q == $past(sample_w ? shifted_w : sh_q))
    else $error("finished byte did not set flag and buffer");

  chk_coll_set: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    wr_data_w && xfer_w
      |=> coll_q && (sh_q == $past(sample_w ? shifted_w : sh_q)))
    else $error("write during transfer not flagged");

  chk_rsvd_zero: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    rd_stat_w |=> WB_ACK_OUT && WB_DAT_OUT[5:1] == 5'h00)
    else $error("reserved status bits not zero");

  chk_off_idle: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    !en_w |-> !MISO_OE_OUT ##1 state_q == spm_pkg::ST_IDLE)
    else $error("disabled port is shifting");

  chk_first_bit: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    start_w |=> busy_w && MOSI_OUT ==
      $past(lsb_w ? WB_DAT_IN[0] : WB_DAT_IN[7]))
    else $error("first bit is not the selected end of the byte");

  chk_vec_clear: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    IRQ_TAKEN_IN && !done_w && !fault_w |=> !done_q ##0 !IRQ_OUT)
    else $error("taking the vector did not clear the flag");

  cov_master_byte: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    master_w && done_w);
  cov_slave_byte: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    !master_w && done_w);
  cov_fault: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    fault_w);
  cov_collision: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    wr_data_w && xfer_w);

endmodule : spm_port

// file: hw/spm_pkg.sv
// Package for the byte-wide SPI master/slave port: register map,
// field positions, reset values, states and the rate decode.
// Assumes a classic Wishbone register bus on a 250 MHz system clock.
//
// How it works
// - Slave: select always input; low activates port, MISO driven if direction says.
// - Slave: select high makes port passive, resets counter, drops partial byte.
// - Master with select as output: select is plain general output.
// - Master with select input pulled low: master_select clears, port becomes slave.
// - That forced drop also sets transfer_done_flag, raising the interrupt if enabled.
// - Modes 0..3 combine idle level and phase; shift and latch opposite edges.
// - clock_idle_level one rests SCK high, zero rests SCK low.
// - clock_phase_sel zero samples leading edge; one samples trailing edge.
// - bit_order one shifts LSB first, zero shifts MSB first.
// - Nothing happens on the link unless port_enable is one; select is still driven from the pin direction register while disabled.
// - Interrupt when transfer_done_flag, irq_enable and global enable are all set.
// - Master SCK divides system clock by 4,16,64,128 or 2,8,32,64.
// - Rate bits do not affect slave operation.
// - transfer_done_flag sets on every finished byte.
// - Flag clears on vector taken, or status read then data access.
// - Data write during transfer sets write_collision_flag; same clearing sequence.
// - Status bits 5 to 1 read as zero.
// - double_rate doubles master SCK; shortest period two system clocks.
// - Data write starts a byte; data read returns receive buffer.
// - Master stops SCK after one byte, sets flag, keeps received byte.
// - Transmit single buffered; unread received byte is overwritten by next.
package spm_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CONTROL = 6'h2C;
  localparam logic [5:0] IDX_STATUS  = 6'h2D;
  localparam logic [5:0] IDX_DATA    = 6'h2E;
  localparam logic [5:0] IDX_PINDIR  = 6'h2F;

  // spi_control fields
  localparam int B_IRQ_EN   = 7;
  localparam int B_PORT_EN  = 6;
  localparam int B_ORDER    = 5;
  localparam int B_MASTER   = 4;
  localparam int B_IDLE_LVL = 3;
  localparam int B_PHASE    = 2;
  localparam int B_RATE_HI  = 1;
  localparam int B_RATE_LO  = 0;

  // spi_status fields
  localparam int B_DONE     = 7;
  localparam int B_COLL     = 6;
  localparam int B_DOUBLE   = 0;

  // Pin direction register fields
  localparam int D_MOSI     = 0;
  localparam int D_MISO     = 1;
  localparam int D_SCK      = 2;
  localparam int D_SS       = 3;
  localparam int D_SS_LEVEL = 4;

  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [4:0] RST_PINDIR  = 5'h00;

  // Byte framing
  localparam logic [3:0] LAST_EDGE   = 4'hF;
  localparam logic [3:0] LAST_SAMPLE = 4'h7;

  typedef enum logic {ST_IDLE = 1'b0, ST_SHIFT = 1'b1} spm_state_t;

  // System clocks per SCK half period for {double_rate, hi, lo}
  function automatic logic [6:0] rate_half(input logic [2:0] code);
    logic [6:0] h;
    h = 7'h02;
    unique case (code)
      3'h0: h = 7'h02;
      3'h1: h = 7'h08;
      3'h2: h = 7'h20;
      3'h3: h = 7'h40;
      3'h4: h = 7'h01;
      3'h5: h = 7'h04;
      3'h6: h = 7'h10;
      3'h7: h = 7'h20;
    endcase
    return h;
  endfunction : rate_half

endpackage : spm_pkg

// file: hw/spm_sync.sv
// Two-flop synchroniser for the four link pins.
// Assumes the inputs are asynchronous to CLK_IN.
module spm_sync (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // Pins and synchronised copies
  input  wire logic [3:0] pins_in,
  output logic      [3:0] pins_out
);

  logic [3:0] meta_q;

  // First stage feeds only the second; select idles high
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      meta_q   <= 4'hF;
      pins_out <= 4'hF;
    end
    else
    begin
      meta_q   <= pins_in;
      pins_out <= meta_q;
    end
  end

endmodule : spm_sync

// file: hw/spm_rate_div.sv
// SCK half-period tick generator for master role.
// Assumes half is held stable while run is high.
module spm_rate_div (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // Control
  input  wire logic       run_in,
  input  wire logic [6:0] half_in,
  // One-cycle pulse per SCK edge
  output logic            tick_out
);

  logic [6:0] cnt_q;

  assign tick_out = run_in && (cnt_q == 7'(half_in - 7'h01));

  // Restarts from zero so the first edge is a full half period away
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      cnt_q <= 7'h00;
    else if (!run_in || tick_out)
      cnt_q <= 7'h00;
    else
      cnt_q <= 7'(cnt_q + 7'h01);
  end

endmodule : spm_rate_div

// file: verif/spm_peer.sv
// Behavioural SPI peer: a slave while the port is master, a master
// otherwise. Assumes the bench resolves each pin from both enables.
module spm_peer (
  // Clock and link setup
  input  wire logic       clk_in,
  input  wire logic [1:0] mode_in,
  input  wire logic       lsb_in,
  // Resolved pins
  input  wire logic       sck_in,
  input  wire logic       mosi_in,
  input  wire logic       miso_in,
  input  wire logic       ss_n_in,
  // Peer drivers
  output logic            sck_out,
  output logic            mosi_out,
  output logic            miso_out,
  output logic            ss_n_out,
  output logic            drv_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] tx_q = 8'h00;
  logic [7:0] rx_q = 8'h00;
  logic       noise = 1'b0;
  int         cnt = 0;
  int         smp = 0;
  logic [2:0] idx;
  logic       bit_w;

  // Bit on the wire; phase one shows it one edge later
  assign idx      = 3'(cnt - int'(mode_in[0]));
  assign bit_w    = lsb_in ? tx_q[idx] : tx_q[3'h7 - idx];
  assign mosi_out = drv_out ? bit_w : noise;
  assign miso_out = (!drv_out && !ss_n_in) ? bit_w : noise;

  // Released lines flip each cycle so no stale bit passes
  always @(posedge clk_in) noise <= ~noise;

  // A new frame restarts both counters
  always @(negedge ss_n_in)
  begin
    cnt = 0;
    smp = 0;
  end

  // Capture on sample edges, advance on setup edges
  always @(sck_in)
  begin
    if (!ss_n_in && smp < 8)
    begin
      if (sck_in == (mode_in[1] ^ mode_in[0] ^ 1'b1))
      begin
        rx_q[lsb_in ? smp : 7 - smp] = drv_out ? miso_in : mosi_in;
        smp++;
      end
      else
        cnt++;
    end
  end

  // Idle driver state
  initial
  begin
    sck_out  = 1'b0;
    ss_n_out = 1'b1;
    drv_out  = 1'b0;
  end

  // Master frame, each phase half clocks, at most fosc/4
  task automatic xfer(input logic [7:0] b, input int bits, input int half);
    tx_q = b;
    sck_out <= mode_in[1];
    drv_out <= 1'b1;
    repeat (half) @(posedge clk_in);
    ss_n_out <= 1'b0;
    repeat (half) @(posedge clk_in);
    repeat (2 * bits)
    begin
      sck_out <= ~sck_out;
      repeat (half) @(posedge clk_in);
    end
    ss_n_out <= 1'b1;
    repeat (half) @(posedge clk_in);
    drv_out <= 1'b0;
  endtask : xfer
endmodule : spm_peer

// file: verif/tb_top.sv
// Self-checking bench for the SPI port: Wishbone tasks, an SPI peer
// and a small queue model. Assumes ack comes one cycle after a request.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] A_CTL = 8'hB0;
  localparam logic [7:0] A_STA = 8'hB4;
  localparam logic [7:0] A_DAT = 8'hB8;
  localparam logic [7:0] A_DIR = 8'hBC;

  logic        clk = 1'b0, rst_n = 1'b0, req = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, seed = 32'h6840D78A;
  logic        cpu_ie = 1'b0, taken = 1'b0, ss_tb = 1'b1, lsb = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic        ack, irq, sck_o, sck_oe, mosi_o, mosi_oe;
  logic        miso_o, miso_oe, ss_o, ss_oe;
  logic        p_sck, p_mosi, p_miso, p_ss, p_drv, sck_p = 1'b0;
  int          error_cnt = 0, total_checks = 0;
  int          edges = 0, gap = 0, gmin = 0, gmax = 0;
  int          divs[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
  logic [7:0]  mdl_q[$];

  // Pin levels from every party's enable; select pulled up
  wire logic sck_w  = sck_oe ? sck_o : p_sck;
  wire logic mosi_w = mosi_oe ? mosi_o : p_mosi;
  wire logic miso_w = miso_oe ? miso_o : p_miso;
  wire logic ss_w   = ss_oe ? ss_o : (p_drv ? p_ss : ss_tb);

  // System clock, 4 ns
  always #2 clk = ~clk;

  spm_port i_dut (
    .CLK_IN(clk), .RESET_N_IN(rst_n), .WB_CYC_IN(req), .WB_STB_IN(req),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_DAT_IN(wdat), .WB_SEL_IN(4'h1),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .CPU_IRQ_EN_IN(cpu_ie),
    .IRQ_TAKEN_IN(taken), .IRQ_OUT(irq), .SCK_IN(sck_w), .SCK_OUT(sck_o),
    .SCK_OE_OUT(sck_oe), .MOSI_IN(mosi_w), .MOSI_OUT(mosi_o),
    .MOSI_OE_OUT(mosi_oe), .MISO_IN(miso_w), .MISO_OUT(miso_o),
    .MISO_OE_OUT(miso_oe), .SS_N_IN(ss_w), .SS_N_OUT(ss_o),
    .SS_N_OE_OUT(ss_oe));

  spm_peer i_peer (
    .clk_in(clk), .mode_in(mode), .lsb_in(lsb), .sck_in(sck_w),
    .mosi_in(mosi_w), .miso_in(miso_w), .ss_n_in(ss_w), .sck_out(p_sck),
    .mosi_out(p_mosi), .miso_out(p_miso), .ss_n_out(p_ss),
    .drv_out(p_drv));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One clock; tracks SCK edge count and spacing as it goes
  task automatic tick();
    @(posedge clk);
    if (sck_o !== sck_p)
    begin
      if (edges > 0 && gap + 1 < gmin) gmin = gap + 1;
      if (edges > 0 && gap + 1 > gmax) gmax = gap + 1;
      edges++;
      gap = 0;
    end
    else
      gap++;
    sck_p = sck_o;
  endtask : tick

  // Classic cycle: hold until ack is sampled, then release a cycle
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    tick();
    while (ack !== 1'b1 && n < 20)
    begin
      tick();
      n++;
    end
    if (n == 20) error_cnt++;
    q = rdat[7:0];
    req <= 1'b0;
    tick();
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask : rdc

  // Software-style wait on the done flag; arms the clear sequence
  task automatic poll_done();
    logic [7:0] q;
    int n;
    n = 0;
    q = 8'h00;
    while (q[7] !== 1'b1 && n < 600)
    begin
      wb(1'b0, A_STA, 8'h00, q);
      n++;
    end
    if (n == 600) error_cnt++;
  endtask : poll_done

  task automatic tally_and_finish();
    $display("TB: checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // Watchdog, well beyond the expected run
  initial
  begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    logic [7:0] tx, sb, q, ctl;
    logic [2:0] c;
    int h;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    tick();
    rdc(A_CTL, 8'h00);
    wr(A_STA, 8'h3E);
    rdc(A_STA, 8'h00);
    wr(8'h00, 8'hFF);
    rdc(8'h00, 8'h00);
    wr(A_DIR, 8'h0D);
    wr(A_CTL, 8'h10);
    edges = 0;
    wr(A_DAT, 8'hA5);
    repeat (100) tick();
    chk(edges, 0);
    rdc(A_STA, 8'h00);
    // Every rate code, all modes and both orders; receive is compared
    // only where a half period covers the input synchroniser
    for (int i = 0; i < 8; i++)
    begin
      c = i[2:0];
      mode = c[1:0] ^ {1'b0, c[2]};
      lsb = c[0];
      ctl = {c[0], 1'b1, c[0], 1'b1, mode, c[1:0]};
      h = divs[i] / 2;
      tx = rnd();
      sb = rnd();
      i_peer.tx_q = sb;
      mdl_q.push_back(sb);
      cpu_ie <= c[1];
      // Mode change first, so the idle-level step lands outside a frame
      wr(A_STA, {7'h00, c[2]});
      wr(A_CTL, ctl);
      wr(A_DIR, 8'h1D);
      wr(A_DIR, 8'h0D);
      chk(sck_o, mode[1]);
      edges = 0;
      gmin = 999;
      gmax = 0;
      wr(A_DAT, tx);
      poll_done();
      chk(edges, 16);
      chk(gmin, h);
      chk(gmax, h);
      chk(sck_o, mode[1]);
      chk(i_peer.rx_q, tx);
      chk(irq, c[0] & c[1]);
      if (c[1])
      begin
        taken <= 1'b1;
        tick();
        taken <= 1'b0;
        tick();
        rdc(A_STA, {7'h00, c[2]});
      end
      wb(1'b0, A_DAT, 8'h00, q);
      sb = mdl_q.pop_front();
      if (h >= 4) chk(q, sb);
      rdc(A_STA, {7'h00, c[2]});
    end
    // A second write mid-byte is dropped and flagged
    wr(A_DIR, 8'h1D);
    wr(A_DIR, 8'h0D);
    tx = rnd();
    wr(A_DAT, tx);
    wr(A_DAT, ~tx);
    poll_done();
    rdc(A_STA, 8'hC1);
    rdc(A_DAT, i_peer.tx_q);
    rdc(A_STA, 8'h01);
    chk(i_peer.rx_q, tx);
    // Select low only counts while the select pin is an input
    ss_tb <= 1'b0;
    repeat (10) tick();
    rdc(A_CTL, ctl);
    wr(A_DIR, 8'h05);
    repeat (6) tick();
    rdc(A_CTL, ctl & 8'hEF);
    chk({sck_oe, mosi_oe}, 2'b00);
    chk(irq, 1'b1);
    rdc(A_STA, 8'h81);
    ss_tb <= 1'b1;
    wb(1'b0, A_DAT, 8'h00, q);
    wr(A_CTL, ctl);
    rdc(A_CTL, ctl);
    // Slave role with random rate bits, an aborted byte between two
    sb = rnd();
    mode = sb[1:0];
    lsb = sb[2];
    wr(A_DIR, 8'h02);
    wr(A_CTL, {2'b01, sb[2], 1'b0, sb[1:0], sb[4:3]});
    chk(miso_oe, 1'b0);
    ss_tb <= 1'b0;
    repeat (5) tick();
    chk(miso_oe, 1'b1);
    ss_tb <= 1'b1;
    repeat (5) tick();
    chk(miso_oe, 1'b0);
    tx = rnd();
    wr(A_DAT, tx);
    i_peer.xfer(rnd(), 8, 6);
    chk(i_peer.rx_q, tx);
    rdc(A_STA, 8'h81);
    i_peer.xfer(rnd(), 3, 6);
    sb = rnd();
    i_peer.xfer(sb, 8, 6);
    rdc(A_DAT, sb);
    rdc(A_STA, 8'h01);
    tally_and_finish();
  end
endmodule : tb_top
